// *** core/timer_pair_pkg.sv ***
// constants, field layouts and encodings of the timer pair common control
package timer_pair_pkg;
  localparam int ADDR_W = 12;
  // register indices; the byte address is four times the index
  localparam logic [7:0] CTRL_IDX = 8'h01;
  localparam logic [7:0] IRQ_IDX = 8'hFA;
  localparam logic [7:0] MASK_IDX = 8'hFB;
  localparam logic [7:0] CFG_IDX = 8'h10;
  localparam logic [1:0] IDX_PAD = 2'h0;
  localparam logic [1:0] ADDR_HI_PAD = 2'h0;

  // common control field positions
  localparam int CTL_WIDE_BIT = 7;
  localparam int CTL_NARROW_BIT = 6;
  localparam int CTL_OPS_LSB = 4;
  localparam int CTL_COMB_LSB = 2;
  localparam int CTL_ROUTE_BIT = 1;

  // interrupt request bit positions
  localparam int IRQ_PIN_TWO_BIT = 0;
  localparam int IRQ_PIN_THREE_BIT = 1;
  localparam int IRQ_PIN_ONE_BIT = 2;
  localparam int IRQ_WIDE_BIT = 3;
  localparam int IRQ_NARROW_BIT = 4;
  localparam int IRQ_VOLT_BIT = 5;
  localparam int IRQ_EDGE_LSB = 6;
  localparam int IRQ_SRC_N = 6;

  localparam int CFG_MODE_BIT = 0;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [5:0] SRC_ZERO = 6'h00;
  localparam logic [1:0] FIELD_ZERO = 2'h0;

  // noise filter lengths in system clock cycles
  localparam int FILT_SHORT_CYC = 4;
  localparam int FILT_LONG_CYC = 8;
  localparam int FILT_CNT_W = 4;

  typedef enum logic [1:0] {
    OPS_NORMAL = 2'b00,
    OPS_PINGPONG = 2'b01,
    OPS_FORCE_LOW = 2'b10,
    OPS_FORCE_HIGH = 2'b11
  } tx_ops_e;

  typedef enum logic [1:0] {
    COMB_AND = 2'b00,
    COMB_OR = 2'b01,
    COMB_NOR = 2'b10,
    COMB_NAND = 2'b11
  } comb_fn_e;

  typedef enum logic [1:0] {
    FILT_NONE = 2'b00,
    FILT_SHORT = 2'b01,
    FILT_LONG = 2'b10,
    FILT_RSVD = 2'b11
  } filt_sel_e;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_UNUSED = 2'b10,
    EDGE_RSVD = 2'b11
  } edge_sel_e;
endpackage

// *** core/demod_filt_if.sv ***
// signals between the common control and its demodulator input filter
`timescale 1ns/100ps
interface demod_filt_if;
  logic sample;
  logic [1:0] sel;
  logic level;
  logic rise;
  logic fall;
  modport owner (output sample, output sel, input level, input rise, input fall);
  modport filter (input sample, input sel, output level, output rise, output fall);
endinterface

// *** core/demod_filter.sv ***
// noise filter and edge detector for the demodulator input
`timescale 1ns/100ps
module demod_filter (
  input wire logic pclk,
  input wire logic presetn,
  demod_filt_if.filter fi
);
  logic [timer_pair_pkg::FILT_CNT_W-1:0] cnt_r;
  logic [timer_pair_pkg::FILT_CNT_W-1:0] len;
  logic level_r;

  // reserved filter code behaves as no filter
  always_comb begin
    case (fi.sel)
      timer_pair_pkg::FILT_SHORT: len = timer_pair_pkg::FILT_CNT_W'(timer_pair_pkg::FILT_SHORT_CYC);
      timer_pair_pkg::FILT_LONG: len = timer_pair_pkg::FILT_CNT_W'(timer_pair_pkg::FILT_LONG_CYC);
      default: len = timer_pair_pkg::FILT_CNT_W'(1);
    endcase
  end

  // a new level is accepted only after it has held for the whole filter length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      level_r <= 1'b0;
    end else if (fi.sample == level_r) begin
      cnt_r <= '0;
    end else if (cnt_r >= len - 1'b1) begin
      cnt_r <= '0;
      level_r <= fi.sample;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign fi.level = level_r;
  assign fi.rise = (cnt_r >= len - 1'b1) && fi.sample && !level_r;
  assign fi.fall = (cnt_r >= len - 1'b1) && !fi.sample && level_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  filter_hold_a: assert property ($changed(level_r)
    |-> level_r == $past(fi.sample) && $past(cnt_r) >= $past(len) - 1'b1)
    else $error("filtered level changed before the filter length elapsed");
endmodule

// *** core/timer_pair_ctrl.sv ***
// common control of the 8-bit and 16-bit timer pair with apb registers
//
// Function
// - in transmit mode the 16-bit timer output starts at the level held in its initial-level control bit.
// - in transmit mode the 8-bit timer output starts at its own initial-level bit, low after reset.
// - in demodulation mode a detected falling edge sets a readable flag that a written one clears.
// - in demodulation mode a detected rising edge sets a readable flag that a written one clears.
// - in transmit mode a two-bit field picks normal, ping-pong, forced low or forced high 16-bit output.
// - in demodulation mode the same field picks no filter, a 4-cycle or an 8-cycle input noise filter.
// - in transmit mode a two-bit field merges the two timer outputs by and, or, nor or nand, and after reset.
// - in demodulation mode the same field picks falling or rising edge detection.
// - in transmit mode a bit routes port three pin six as plain port output or as the merged timer output.
// - in demodulation mode the same bit picks port three pin one or port two pin zero as input.
// - interrupt requests 0 to 5 come from pins 3.2, 3.3, 3.1, the 16-bit timer, the 8-bit timer and low voltage.
// - a two-bit field selects the active edges of the pin 3.1 and pin 3.2 interrupts.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
module timer_pair_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_pair_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port_three_pin_one,
  input wire logic port_three_pin_two,
  input wire logic port_three_pin_three,
  input wire logic port_two_pin_zero,
  input wire logic timers_running,
  input wire logic wide_timer_terminal,
  input wire logic narrow_timer_terminal,
  input wire logic low_voltage_detect_event,
  input wire logic port_six_data,
  output logic wide_timer_output,
  output logic narrow_timer_output,
  output logic port_three_pin_six,
  output logic demod_level,
  output logic irq
);
  localparam int PIN_N = 4;
  localparam int PIN_ONE = 0;
  localparam int PIN_TWO = 1;
  localparam int PIN_THREE = 2;
  localparam int PIN_ALT = 3;

  function automatic logic hit(input logic [timer_pair_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == {timer_pair_pkg::ADDR_HI_PAD, idx, timer_pair_pkg::IDX_PAD});
  endfunction

  function automatic logic merge(input logic [1:0] fn, input logic n, input logic w);
    case (fn)
      timer_pair_pkg::COMB_AND: merge = n & w;
      timer_pair_pkg::COMB_OR: merge = n | w;
      timer_pair_pkg::COMB_NOR: merge = ~(n | w);
      default: merge = ~(n & w);
    endcase
  endfunction

  // pin synchronisers
  logic [PIN_N-1:0] pins_in;
  logic [PIN_N-1:0] meta_r;
  logic [PIN_N-1:0] sync_r;
  logic [PIN_N-1:0] prev_r;
  assign pins_in = {port_two_pin_zero, port_three_pin_three, port_three_pin_two, port_three_pin_one};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
          prev_r[gi] <= 1'b0;
        end else begin
          meta_r[gi] <= pins_in[gi];
          sync_r[gi] <= meta_r[gi];
          prev_r[gi] <= sync_r[gi];
        end
      end
    end
  endgenerate

  // registers
  logic demod_r;
  logic wide_init_r;
  logic narrow_init_r;
  logic fall_flag_r;
  logic rise_flag_r;
  logic [1:0] ops_r;
  logic [1:0] comb_r;
  logic route_r;
  logic [1:0] irq_edge_r;
  logic [timer_pair_pkg::IRQ_SRC_N-1:0] irq_sts_r;
  logic [timer_pair_pkg::IRQ_SRC_N-1:0] irq_sts_nxt;
  logic [timer_pair_pkg::IRQ_SRC_N-1:0] irq_mask_r;
  logic [timer_pair_pkg::IRQ_SRC_N-1:0] irq_set;
  logic pp_wide_r;

  // apb: setup cycle prepares the answer, access phase completes without wait
  logic setup;
  logic access;
  logic mapped;
  logic wr;
  logic [7:0] rd_val;
  logic [7:0] ctrl_rd;
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign mapped = hit(paddr, timer_pair_pkg::CTRL_IDX) || hit(paddr, timer_pair_pkg::IRQ_IDX)
    || hit(paddr, timer_pair_pkg::MASK_IDX) || hit(paddr, timer_pair_pkg::CFG_IDX);
  assign wr = access && pwrite && !pslverr;

  // same bits read back with mode-dependent meaning
  always_comb begin
    ctrl_rd = timer_pair_pkg::BYTE_ZERO;
    ctrl_rd[timer_pair_pkg::CTL_WIDE_BIT] = demod_r ? fall_flag_r : wide_init_r;
    ctrl_rd[timer_pair_pkg::CTL_NARROW_BIT] = demod_r ? rise_flag_r : narrow_init_r;
    ctrl_rd[timer_pair_pkg::CTL_OPS_LSB +: 2] = ops_r;
    ctrl_rd[timer_pair_pkg::CTL_COMB_LSB +: 2] = comb_r;
    ctrl_rd[timer_pair_pkg::CTL_ROUTE_BIT] = route_r;
  end

  always_comb begin
    rd_val = timer_pair_pkg::BYTE_ZERO;
    if (hit(paddr, timer_pair_pkg::CTRL_IDX)) begin
      rd_val = ctrl_rd;
    end else if (hit(paddr, timer_pair_pkg::IRQ_IDX)) begin
      rd_val = {irq_edge_r, irq_sts_r};
    end else if (hit(paddr, timer_pair_pkg::MASK_IDX)) begin
      rd_val = {timer_pair_pkg::FIELD_ZERO, irq_mask_r};
    end else if (hit(paddr, timer_pair_pkg::CFG_IDX)) begin
      rd_val[timer_pair_pkg::CFG_MODE_BIT] = demod_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata <= {24'h000000, rd_val};
      end
    end
  end

  logic wr_ctrl;
  logic wr_irq;
  assign wr_ctrl = wr && hit(paddr, timer_pair_pkg::CTRL_IDX);
  assign wr_irq = wr && hit(paddr, timer_pair_pkg::IRQ_IDX);

  // mode switch is taken as written; timers are assumed stopped by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      demod_r <= 1'b0;
      irq_mask_r <= timer_pair_pkg::SRC_ZERO;
    end else if (wr && hit(paddr, timer_pair_pkg::CFG_IDX)) begin
      demod_r <= pwdata[timer_pair_pkg::CFG_MODE_BIT];
    end else if (wr && hit(paddr, timer_pair_pkg::MASK_IDX)) begin
      irq_mask_r <= pwdata[timer_pair_pkg::IRQ_SRC_N-1:0];
    end
  end

  // shared control fields; initial levels are only writable in transmit mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wide_init_r <= 1'b0;
      narrow_init_r <= 1'b0;
      ops_r <= timer_pair_pkg::OPS_NORMAL;
      comb_r <= timer_pair_pkg::COMB_AND;
      route_r <= 1'b0;
    end else if (wr_ctrl) begin
      if (!demod_r) begin
        wide_init_r <= pwdata[timer_pair_pkg::CTL_WIDE_BIT];
        narrow_init_r <= pwdata[timer_pair_pkg::CTL_NARROW_BIT];
      end
      ops_r <= pwdata[timer_pair_pkg::CTL_OPS_LSB +: 2];
      comb_r <= pwdata[timer_pair_pkg::CTL_COMB_LSB +: 2];
      route_r <= pwdata[timer_pair_pkg::CTL_ROUTE_BIT];
    end
  end

  // demodulator path
  demod_filt_if fi ();
  assign fi.sample = route_r ? sync_r[PIN_ALT] : sync_r[PIN_ONE];
  assign fi.sel = ops_r;

  demod_filter u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .fi(fi.filter)
  );

  logic fall_hit;
  logic rise_hit;
  logic fall_clr;
  logic rise_clr;
  assign fall_hit = demod_r && fi.fall && comb_r == timer_pair_pkg::EDGE_FALL;
  assign rise_hit = demod_r && fi.rise && comb_r == timer_pair_pkg::EDGE_RISE;
  assign fall_clr = wr_ctrl && demod_r && pwdata[timer_pair_pkg::CTL_WIDE_BIT];
  assign rise_clr = wr_ctrl && demod_r && pwdata[timer_pair_pkg::CTL_NARROW_BIT];

  // an edge in the same cycle as the clear wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fall_flag_r <= 1'b0;
      rise_flag_r <= 1'b0;
      demod_level <= 1'b0;
    end else begin
      fall_flag_r <= fall_hit || (fall_flag_r && !fall_clr);
      rise_flag_r <= rise_hit || (rise_flag_r && !rise_clr);
      demod_level <= fi.level;
    end
  end

  // transmit outputs
  logic pp_mode;
  assign pp_mode = ops_r == timer_pair_pkg::OPS_PINGPONG;

  // ping-pong hands over on terminal count, narrow timer first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pp_wide_r <= 1'b0;
    end else if (!timers_running || !pp_mode) begin
      pp_wide_r <= 1'b0;
    end else if (pp_wide_r && wide_timer_terminal) begin
      pp_wide_r <= 1'b0;
    end else if (!pp_wide_r && narrow_timer_terminal) begin
      pp_wide_r <= 1'b1;
    end
  end

  // outputs hold in demodulation mode since the bits mean something else there
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wide_timer_output <= 1'b0;
    end else if (!demod_r) begin
      if (!timers_running) begin
        wide_timer_output <= wide_init_r;
      end else begin
        case (ops_r)
          timer_pair_pkg::OPS_FORCE_LOW: wide_timer_output <= 1'b0;
          timer_pair_pkg::OPS_FORCE_HIGH: wide_timer_output <= 1'b1;
          timer_pair_pkg::OPS_PINGPONG: wide_timer_output <= wide_timer_output ^ (pp_wide_r && wide_timer_terminal);
          default: wide_timer_output <= wide_timer_output ^ wide_timer_terminal;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      narrow_timer_output <= 1'b0;
    end else if (!demod_r) begin
      if (!timers_running) begin
        narrow_timer_output <= narrow_init_r;
      end else if (pp_mode) begin
        narrow_timer_output <= narrow_timer_output ^ (!pp_wide_r && narrow_timer_terminal);
      end else begin
        narrow_timer_output <= narrow_timer_output ^ narrow_timer_terminal;
      end
    end
  end

  // pin six is plain port data in demodulation mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_three_pin_six <= 1'b0;
    end else if (!demod_r && route_r) begin
      port_three_pin_six <= merge(comb_r, narrow_timer_output, wide_timer_output);
    end else begin
      port_three_pin_six <= port_six_data;
    end
  end

  // interrupt requests
  logic one_rise;
  logic one_fall;
  logic two_rise;
  logic two_fall;
  assign one_rise = sync_r[PIN_ONE] && !prev_r[PIN_ONE];
  assign one_fall = !sync_r[PIN_ONE] && prev_r[PIN_ONE];
  assign two_rise = sync_r[PIN_TWO] && !prev_r[PIN_TWO];
  assign two_fall = !sync_r[PIN_TWO] && prev_r[PIN_TWO];

  always_comb begin
    irq_set = timer_pair_pkg::SRC_ZERO;
    irq_set[timer_pair_pkg::IRQ_PIN_ONE_BIT] = (irq_edge_r[1] && one_rise) ||
      ((irq_edge_r == 2'b11 || !irq_edge_r[1]) && one_fall);
    irq_set[timer_pair_pkg::IRQ_PIN_TWO_BIT] = (irq_edge_r[0] && two_rise) ||
      ((irq_edge_r == 2'b11 || !irq_edge_r[0]) && two_fall);
    irq_set[timer_pair_pkg::IRQ_PIN_THREE_BIT] = !sync_r[PIN_THREE] && prev_r[PIN_THREE];
    irq_set[timer_pair_pkg::IRQ_WIDE_BIT] = wide_timer_terminal;
    irq_set[timer_pair_pkg::IRQ_NARROW_BIT] = narrow_timer_terminal;
    irq_set[timer_pair_pkg::IRQ_VOLT_BIT] = low_voltage_detect_event;
  end

  always_comb begin
    irq_sts_nxt = irq_sts_r;
    if (wr_irq) begin
      irq_sts_nxt = irq_sts_r & ~pwdata[timer_pair_pkg::IRQ_SRC_N-1:0];
    end
    irq_sts_nxt = irq_sts_nxt | irq_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_r <= timer_pair_pkg::SRC_ZERO;
      irq_edge_r <= timer_pair_pkg::FIELD_ZERO;
      irq <= 1'b0;
    end else begin
      irq_sts_r <= irq_sts_nxt;
      if (wr_irq) begin
        irq_edge_r <= pwdata[timer_pair_pkg::IRQ_EDGE_LSB +: 2];
      end
      irq <= |(irq_sts_nxt & irq_mask_r);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wide_init_a: assert property (!demod_r && !timers_running
    |=> wide_timer_output == $past(wide_init_r)) else $error("16-bit output not at initial level");
  narrow_init_a: assert property (!demod_r && !timers_running
    |=> narrow_timer_output == $past(narrow_init_r)) else $error("8-bit output not at initial level");
  fall_flag_a: assert property (fall_hit
    |=> fall_flag_r ##1 (fall_flag_r || $past(fall_clr)))
    else $error("falling edge flag not set or not held");
  rise_flag_a: assert property (rise_hit ##1 !rise_clr |=> rise_flag_r)
    else $error("rising edge flag not set or not held");
  force_level_a: assert property (!demod_r && timers_running && ops_r == timer_pair_pkg::OPS_FORCE_HIGH
    |=> wide_timer_output) else $error("16-bit output not forced high");
  merge_out_a: assert property (!demod_r && route_r |=> port_three_pin_six
    == merge($past(comb_r), $past(narrow_timer_output), $past(wide_timer_output)))
    else $error("pin six not the merged timer output");
  edge_gate_a: assert property (demod_r && comb_r == timer_pair_pkg::EDGE_RISE
    && !fall_flag_r |=> !fall_flag_r) else $error("falling flag set while rising edge selected");
  port_route_a: assert property (!demod_r && !route_r |=> port_three_pin_six == $past(port_six_data))
    else $error("pin six not plain port data");
  timer_req_a: assert property (wide_timer_terminal
    |=> irq_sts_r[timer_pair_pkg::IRQ_WIDE_BIT] ##1 (irq_sts_r[timer_pair_pkg::IRQ_WIDE_BIT] || $past(wr_irq)))
    else $error("16-bit timer request not latched");
  pin_edge_a: assert property (irq_edge_r == 2'b00 && one_rise
    && !irq_sts_r[timer_pair_pkg::IRQ_PIN_ONE_BIT] |=> !irq_sts_r[timer_pair_pkg::IRQ_PIN_ONE_BIT])
    else $error("pin 3.1 rising edge taken while falling only");

  pingpong_c: cover property (pp_mode && pp_wide_r && wide_timer_terminal);
  fall_flag_c: cover property (fall_hit ##[1:20] fall_clr);
  irq_raise_c: cover property ($rose(irq));
endmodule

// *** testbench/ext_pins.sv ***
// partner model of the external pins feeding the demodulator and pin interrupts
`timescale 1ns/100ps
module ext_pins (
  input wire logic pclk,
  output logic port_three_pin_one,
  output logic port_three_pin_two,
  output logic port_three_pin_three,
  output logic port_two_pin_zero
);
  // pins idle high as if pulled up; index 0..3 is pin 3.1, 3.2, 3.3, 2.0
  logic [3:0] lv = 4'hF;
  assign port_three_pin_one = lv[0];
  assign port_three_pin_two = lv[1];
  assign port_three_pin_three = lv[2];
  assign port_two_pin_zero = lv[3];
  task set_pin(input int i, input logic v);
    @(posedge pclk);
    lv[i] <= v;
  endtask
  // an excursion shorter than the filter, which must be rejected
  task glitch(input int i, input logic v, input int len);
    set_pin(i, v);
    repeat (len) @(posedge pclk);
    lv[i] <= ~v;
  endtask
endmodule

// *** testbench/test_timer_pair_ctrl.sv ***
// self-checking bench for the timer pair common control
`timescale 1ns/100ps
module test_timer_pair_ctrl;
  localparam int LIMIT = 20000;
  localparam logic [7:0] CT = timer_pair_pkg::CTRL_IDX;
  localparam logic [7:0] IQ = timer_pair_pkg::IRQ_IDX;
  localparam logic [7:0] MK = timer_pair_pkg::MASK_IDX;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [timer_pair_pkg::ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, pin_one, pin_two, pin_three, pin_alt;
  logic run = 1'b0, wterm = 1'b0, nterm = 1'b0, lvd_ev = 1'b0, p6 = 1'b0;
  logic wout, nout, pin6, dlev, irq;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #4 pclk = ~pclk;
  ext_pins pins (.pclk(pclk), .port_three_pin_one(pin_one), .port_three_pin_two(pin_two),
    .port_three_pin_three(pin_three), .port_two_pin_zero(pin_alt));
  timer_pair_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_three_pin_one(pin_one), .port_three_pin_two(pin_two), .port_three_pin_three(pin_three),
    .port_two_pin_zero(pin_alt), .timers_running(run), .wide_timer_terminal(wterm),
    .narrow_timer_terminal(nterm), .low_voltage_detect_event(lvd_ev), .port_six_data(p6),
    .wide_timer_output(wout), .narrow_timer_output(nout), .port_three_pin_six(pin6),
    .demod_level(dlev), .irq(irq));
  task give_verdict;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // edges then 1 ns, so registered outputs have settled
  task tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {timer_pair_pkg::ADDR_HI_PAD, idx, timer_pair_pkg::IDX_PAD};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // answer and read data are taken at the edge that completes the access
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask
  task rdc(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    logic e;
    apb(1'b0, idx, 8'h00, r, e);
    check(nm, exp, r);
  endtask
  task term(input logic w);
    @(posedge pclk);
    wterm <= w;
    nterm <= ~w;
    @(posedge pclk);
    wterm <= 1'b0;
    nterm <= 1'b0;
    tick(2);
  endtask
  task t_reset;
    logic [7:0] r;
    logic e;
    rdc("ctrl reset", CT, 8'h00);
    rdc("flags reset", IQ, 8'h00);
    apb(1'b0, 8'h20, 8'h00, r, e);
    check("unmapped err", 8'h01, {7'h00, e});
    check("outputs reset", 8'h00, {4'h0, wout, nout, pin6, irq});
  endtask
  task t_levels;
    logic [3:0] tbl;
    // wide high, narrow low: and, or, nor, nand
    tbl = 4'b1010;
    p6 <= 1'b1;
    wr(CT, 8'hC0);
    tick(3);
    check("initial levels", 8'h03, {6'h00, wout, nout});
    check("pin6 as port", 8'h01, {7'h00, pin6});
    rdc("ctrl readback", CT, 8'hC0);
    for (int k = 0; k < 4; k++) begin
      wr(CT, {4'b1000, k[1:0], 2'b10});
      tick(3);
      check("merged pin6", {7'h00, tbl[k]}, {7'h00, pin6});
    end
    wr(CT, 8'h30);
    // forcing only acts while the timers run
    run <= 1'b1;
    tick(3);
    check("forced high", 8'h01, {7'h00, wout});
    wr(CT, 8'hA0);
    tick(3);
    check("forced low", 8'h00, {7'h00, wout});
  endtask
  task t_timers;
    wr(CT, 8'h10);
    run <= 1'b1;
    term(1'b1);
    check("idle wide holds", 8'h00, {6'h00, wout, nout});
    term(1'b0);
    check("narrow toggles", 8'h01, {6'h00, wout, nout});
    term(1'b1);
    check("wide toggles", 8'h03, {6'h00, wout, nout});
    rdc("tc requests", IQ, 8'h18);
    wr(MK, 8'h08);
    tick(2);
    check("irq unmasked", 8'h01, {7'h00, irq});
    wr(IQ, 8'h08);
    tick(2);
    check("irq cleared", 8'h00, {7'h00, irq});
    rdc("w1c one bit", IQ, 8'h10);
    wr(MK, 8'h00);
    tick(2);
    check("irq masked", 8'h00, {7'h00, irq});
    @(posedge pclk);
    run <= 1'b0;
    lvd_ev <= 1'b1;
    @(posedge pclk);
    lvd_ev <= 1'b0;
    wr(IQ, 8'h10);
    rdc("low voltage", IQ, 8'h20);
  endtask
  task t_edges;
    int pi[9] = '{1, 2, 1, 0, 0, 1, 1, 0, 0};
    logic lv[9] = '{0, 0, 1, 0, 1, 0, 1, 0, 1};
    logic [1:0] sl[9] = '{0, 0, 1, 1, 2, 2, 3, 3, 0};
    logic [7:0] ex[9] = '{8'h01, 8'h02, 8'h41, 8'h44, 8'h84, 8'h81, 8'hC1, 8'hC4, 8'h00};
    for (int i = 0; i < 9; i++) begin
      wr(IQ, {sl[i], 6'h3F});
      pins.set_pin(pi[i], lv[i]);
      tick(8);
      rdc("pin request", IQ, ex[i]);
    end
  endtask
  task t_demod;
    wr(timer_pair_pkg::CFG_IDX, 8'h01); // timers already stopped
    wr(CT, 8'h00);
    tick(4);
    pins.set_pin(0, 1'b0);
    tick(8);
    check("demod level", 8'h00, {7'h00, dlev});
    rdc("fall flag", CT, 8'h80);
    wr(CT, 8'h00);
    rdc("flag kept", CT, 8'h80);
    wr(CT, 8'h80);
    rdc("flag cleared", CT, 8'h00);
    wr(CT, 8'h04);
    pins.set_pin(0, 1'b1);
    tick(8);
    rdc("rise flag", CT, 8'h44);
    wr(CT, 8'h54);
    pins.glitch(0, 1'b0, 2);
    tick(12);
    check("short glitch", 8'h01, {7'h00, dlev});
    rdc("no flag 4", CT, 8'h14);
    wr(CT, 8'h20);
    pins.glitch(0, 1'b0, 6);
    tick(16);
    rdc("no flag 8", CT, 8'h20);
    pins.set_pin(0, 1'b0);
    tick(14);
    check("long filter", 8'h00, {7'h00, dlev});
    rdc("fall after 8", CT, 8'hA0);
    wr(CT, 8'h82);
    pins.set_pin(0, 1'b1);
    tick(8);
    pins.set_pin(0, 1'b0);
    tick(8);
    rdc("other pin ignored", CT, 8'h02);
    pins.set_pin(3, 1'b0);
    tick(8);
    rdc("port two input", CT, 8'h82);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      give_verdict;
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    tick(1);
    t_reset;
    t_levels;
    t_timers;
    t_edges;
    t_demod;
    give_verdict;
  end
endmodule
